//--- osc_pkg.sv
/*
 * Constants shared by the on/off switch controller: oscillator timing,
 * jitter, blanking, auto-restart windows, current-limit steps and the
 * AHB-Lite register map.
 * Assumes a single 250 MHz system clock.
 */
package osc_pkg;
    localparam int CLK_HZ = 250_000_000;
    // oscillator, average rate and jitter
    localparam int OSC_HZ = 132_000;
    localparam int JIT_PP_HZ = 8_000;
    localparam int JIT_RATE_HZ = 1_000;
    localparam int OSC_PER_CYC = CLK_HZ / OSC_HZ;
    localparam int JIT_SPAN_CYC = (CLK_HZ / (OSC_HZ - JIT_PP_HZ / 2))
        - (CLK_HZ / (OSC_HZ + JIT_PP_HZ / 2));
    localparam int JIT_STEPS = OSC_HZ / JIT_RATE_HZ;
    // duty ceiling as percent of the period
    localparam int DUTY_MAX_PCT = 65;
    localparam int DUTY_CYC = OSC_PER_CYC * DUTY_MAX_PCT / 100;
    // leading-edge blanking, least time rounds up
    localparam int BLANK_NS = 200;
    localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // auto-restart windows in oscillator cycles
    localparam int AR_ON_MS = 50;
    localparam int AR_OFF_MS = 850;
    localparam int AR_ON_CNT = AR_ON_MS * OSC_HZ / 1000;
    localparam int AR_OFF_CNT = AR_OFF_MS * OSC_HZ / 1000;
    localparam int AR_W = 17;
    // current limit levels, coded for the analog threshold select
    localparam logic [1:0] LIM_FULL = 2'h0;
    localparam logic [1:0] LIM_MED = 2'h1;
    localparam logic [1:0] LIM_LOW = 2'h2;
    localparam int LOAD_WIN = 8;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_ARCNT = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_JIT_BIT = 1;
endpackage

//--- osc_tick_if.sv
/*
 * Oscillator to controller bundle: cycle start strobe and duty ceiling.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface osc_tick_if;
    logic cycStart;
    logic dutyCeil;
    modport src (output cycStart, output dutyCeil);
    modport dst (input cycStart, input dutyCeil);
endinterface

//--- osc_jitter_osc.sv
/*
 * Jittered oscillator: triangle-modulated period around the average rate,
 * one-cycle start pulse and a duty ceiling level.
 * Assumes synchronous reset copy from the top.
 */
`timescale 1ns/1ps
module osc_jitter_osc
    import osc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic jitEn,
    // ticks
    osc_tick_if.src tick
);
    import osc_pkg::*;
    localparam logic [12:0] PER0 = 13'(OSC_PER_CYC - JIT_SPAN_CYC / 2);
    localparam logic [12:0] SPAN = 13'(JIT_SPAN_CYC);
    localparam logic [12:0] STEPDIV = 13'(JIT_STEPS / 2);
    logic [12:0] cnt_q;
    logic [12:0] offs_q;
    logic [7:0] step_q;
    logic up_q;
    logic [12:0] per;

    always_comb begin
        per = jitEn ? 13'(PER0 + 26'(offs_q) * SPAN / STEPDIV) : 13'(OSC_PER_CYC);
    end

    // period counter
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cnt_q <= 13'h0;
        end else if (cnt_q >= per - 13'h1) begin
            cnt_q <= 13'h0;
        end else begin
            cnt_q <= cnt_q + 13'h1;
        end
    end

    // triangle sweep of the period, one full sweep per modulation period
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            offs_q <= 13'h0;
            step_q <= 8'h0;
            up_q <= 1'b1;
        end else if (cnt_q == 13'h0) begin
            step_q <= step_q + 8'h1;
            // offs_q counts sweep steps; a fixed add per step would round the span away
            if (up_q) begin
                offs_q <= (offs_q >= STEPDIV) ? STEPDIV : offs_q + 13'h1;
            end else begin
                offs_q <= (offs_q == 13'h0) ? 13'h0 : offs_q - 13'h1;
            end
            if ({5'h0, step_q} >= STEPDIV - 13'h1) begin
                step_q <= 8'h0;
                up_q <= ~up_q;
            end
        end
    end

    assign tick.cycStart = (cnt_q == 13'h0);
    assign tick.dutyCeil = (cnt_q >= 13'(DUTY_CYC));
endmodule

//--- osc_switch_ctrl.sv
/*
 * On/off switch controller: decides each oscillator cycle whether to fire
 * the power switch, with lockouts, peak-current end, blanking, load-driven
 * current limit, auto-restart and line undervoltage gating. AHB-Lite slave.
 * Assumes comparator inputs are synchronous to clk; analog parts are outside.
 */
// Register access over AHB-Lite and the register offsets were left to the implementer.
//Contract
//- supply low forces off until supply good
//- overtemp disables switching until cooled indication
//- peak current ends pulse for cycle
//- ignore current comparator during blanking interval
//- load sequence lowers current limit in steps
//- restart counter cleared whenever feedback low
//- no feedback 50 ms, off 850 ms
//- alternate windows until feedback low again
//- line undervoltage halts restart off counter
//- start only with line current above 49uA
//- hold supply at 4.8 V during undervoltage; code holds only while powered_q is low, before the first start and again after a supply lockout
//- no sense resistor disables undervoltage gating
//- on at start, off at limit/ceiling
//- finish started cycle, ignore feedback changes
//- supply regulator charges only while switch off
//- sample feedback once at cycle start
//- feedback low when outflow above 240uA
//- oscillator 132 kHz, start and ceiling
//- jitter 8 kHz pp at 1 kHz
`timescale 1ns/1ps
module osc_switch_ctrl
    import osc_pkg::*;
#(
    // auto-restart windows in oscillator cycles
    parameter int ON_CNT = AR_ON_CNT,
    parameter int OFF_CNT = AR_OFF_CNT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // analog comparators
    input wire logic fbOutflowHigh,
    input wire logic lineCurOk,
    input wire logic senseAbsent,
    input wire logic supplyLow,
    input wire logic supplyGood,
    input wire logic overTemp,
    input wire logic tempCooled,
    input wire logic peakCurTrip,
    // power stage
    output logic gateOn,
    output logic [1:0] limitSel,
    output logic regChargeEn,
    output logic supplyHoldLow,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import osc_pkg::*;

    // restart sequencer states, one-hot as shown in the status word
    typedef enum logic [2:0] {
        AR_RUN = 3'b001,
        AR_OFF = 3'b010,
        AR_WAITLINE = 3'b100
    } osc_ar_t;

    logic rstMeta_q, rstSync_n;
    logic uvlo_q, hot_q, gate_q, enSamp_q, lineOk_q, powered_q;
    logic [7:0] blank_q;
    logic [AR_W-1:0] arCnt_q;
    osc_ar_t ar_q;
    logic [LOAD_WIN-1:0] hist_q;
    logic [1:0] lim_q;
    logic [31:0] ctrl_q;
    logic wrPend_q;
    logic [7:0] addr_q;
    logic [31:0] rdata_q;
    logic fbLow, uvActive, allowed;
    logic [3:0] ones;

    osc_tick_if tick ();

    osc_jitter_osc u_osc (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .jitEn(ctrl_q[CTRL_JIT_BIT]),
        .tick(tick)
    );

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_n <= rstMeta_q;
        end
    end

    // a large outflow means the secondary wants no energy this cycle
    assign fbLow = fbOutflowHigh;
    assign uvActive = !senseAbsent && !lineCurOk;

    // supply lockout with hysteresis
    // starts locked, so the first pulse waits for a supply-good report
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            uvlo_q <= 1'b1;
        end else if (supplyLow) begin
            uvlo_q <= 1'b1;
        end else if (supplyGood) begin
            uvlo_q <= 1'b0;
        end
    end

    // thermal lockout
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            hot_q <= 1'b0;
        end else if (overTemp) begin
            hot_q <= 1'b1;
        end else if (tempCooled) begin
            hot_q <= 1'b0;
        end
    end

    // first start after power-up waits for line current
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            powered_q <= 1'b0;
        end else if (!uvActive && !uvlo_q) begin
            powered_q <= 1'b1;
        end else if (uvlo_q) begin
            powered_q <= 1'b0;
        end
    end
    // keep the supply at its low level until the line is up
    assign supplyHoldLow = !powered_q && uvActive;

    // auto-restart sequencer, counts oscillator cycles
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ar_q <= AR_RUN;
            arCnt_q <= '0;
        end else begin
            case (ar_q)
                AR_RUN: begin
                    if (fbLow) begin
                        arCnt_q <= '0;
                    end else if (tick.cycStart) begin
                        if (arCnt_q >= AR_W'(ON_CNT - 1)) begin
                            ar_q <= AR_OFF;
                            arCnt_q <= '0;
                        end else begin
                            arCnt_q <= arCnt_q + 1'b1;
                        end
                    end
                end
                AR_OFF: begin
                    // counter stalls while the line is low
                    if (tick.cycStart && !uvActive) begin
                        if (arCnt_q >= AR_W'(OFF_CNT - 1)) begin
                            ar_q <= AR_WAITLINE;
                            arCnt_q <= '0;
                        end else begin
                            arCnt_q <= arCnt_q + 1'b1;
                        end
                    end
                end
                AR_WAITLINE: begin
                    // off window done; a low line still keeps the switch idle
                    if (!uvActive) begin
                        ar_q <= AR_RUN;
                    end
                end
                default: begin
                    ar_q <= AR_RUN;
                    arCnt_q <= '0;
                end
            endcase
        end
    end

    // lockouts end a pulse under way; only feedback is ignored mid-cycle
    assign allowed = ctrl_q[CTRL_EN_BIT] && !uvlo_q && !hot_q && powered_q
        && (ar_q == AR_RUN);

    // per-cycle enable sample; held for the whole cycle
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            enSamp_q <= 1'b0;
        end else if (tick.cycStart) begin
            enSamp_q <= !fbLow;
        end
    end

    // gate drive: on at start, off on trip after blanking or duty ceiling
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            gate_q <= 1'b0;
            blank_q <= 8'h0;
        end else if (!allowed || uvlo_q) begin
            gate_q <= 1'b0;
        end else if (tick.cycStart) begin
            gate_q <= !fbLow;
            blank_q <= 8'(BLANK_CYC);
        end else begin
            if (blank_q != 8'h0) begin
                blank_q <= blank_q - 8'h1;
            end
            if (tick.dutyCeil || (peakCurTrip && blank_q == 8'h0)) begin
                gate_q <= 1'b0;
            end
        end
    end
    assign gateOn = gate_q;
    assign regChargeEn = !gate_q;

    // load estimate from enabled-cycle density over a sliding window
    always_comb begin
        ones = 4'h0;
        for (int i = 0; i < LOAD_WIN; i++) begin
            ones = ones + 4'(hist_q[i]);
        end
    end

    // enabled cycles in the window needed for the full and medium limits
    localparam logic [3:0] HEAVY_MIN = 4'h6;
    localparam logic [3:0] MED_MIN = 4'h3;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            hist_q <= '0;
            lim_q <= LIM_FULL;
        end else if (tick.cycStart) begin
            hist_q <= {hist_q[LOAD_WIN-2:0], !fbLow};
            if (ones >= HEAVY_MIN) begin
                lim_q <= LIM_FULL;
            end else if (ones >= MED_MIN) begin
                lim_q <= LIM_MED;
            end else begin
                lim_q <= LIM_LOW;
            end
        end
    end
    assign limitSel = lim_q;

    // AHB-Lite: zero wait states, always OKAY
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wrPend_q <= 1'b0;
            addr_q <= 8'h0;
        end else if (hready) begin
            wrPend_q <= hsel && htrans[1] && hwrite;
            addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctrl_q <= CTRL_RST;
        end else if (wrPend_q && addr_q == REG_CTRL) begin
            // bits above the two controls are not kept
            ctrl_q <= {30'h0, hwdata[1:0]};
        end
    end

    // read data decoded in the address phase so it stands in the data phase,
    // and zero in every other cycle with hready high so no stale word lingers on the bus
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rdata_q <= 32'h0;
        end else if (hready) begin
            rdata_q <= 32'h0;
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    REG_CTRL: rdata_q <= ctrl_q;
                    REG_STAT: rdata_q <= {21'h0, lim_q, ar_q, 1'b0, enSamp_q, powered_q,
                        hot_q, uvlo_q, gate_q};
                    REG_ARCNT: rdata_q <= {15'h0, arCnt_q};
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

//--- osc_switch_ctrl_monitor.sv
/*
 * Port checker for the on/off switch controller: gate timing, lockouts,
 * blanking, supply charge enable and the AHB-Lite slave answers.
 * Assumes one clock and the top module's asynchronous rst_n.
 */
`timescale 1ns/1ps
module osc_switch_ctrl_monitor
    import osc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // comparators
    input wire logic supplyLow,
    input wire logic overTemp,
    input wire logic peakCurTrip,
    input wire logic senseAbsent,
    // power stage
    input wire logic gateOn,
    input wire logic [1:0] limitSel,
    input wire logic regChargeEn,
    input wire logic supplyHoldLow,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    int onCnt;
    int gapCnt;
    logic rdPh;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // gapCnt saturates so the first pulse after reset is never judged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            onCnt <= 0;
            gapCnt <= 100000;
            rdPh <= 1'b0;
        end else begin
            onCnt <= gateOn ? onCnt + 1 : 0;
            if (gateOn && onCnt == 0) begin
                gapCnt <= 1;
            end else if (gapCnt < 100000) begin
                gapCnt <= gapCnt + 1;
            end
            rdPh <= hsel && hready && htrans[1] && !hwrite;
        end
    end
    sequence sRise;
        gateOn && onCnt == 0;
    endsequence
    sequence sLateTrip;
        gateOn && onCnt > BLANK_CYC + 1 && peakCurTrip;
    endsequence
    a_one_pulse: assert property (sRise |-> gapCnt >= OSC_PER_CYC - JIT_SPAN_CYC)
        else $error("gate pulses closer than one oscillator period");
    a_trip_ends: assert property (sLateTrip |=> !gateOn)
        else $error("gate still on after current trip");
    a_blank_hold: assert property (gateOn && onCnt < BLANK_CYC - 1 && !supplyLow && !overTemp
        |=> gateOn)
        else $error("pulse ended inside blanking");
    a_duty_ceiling: assert property (gateOn |-> onCnt <= DUTY_CYC)
        else $error("pulse longer than duty ceiling");
    a_charge_off: assert property (regChargeEn == !gateOn)
        else $error("charge enable while switch on");
    a_low_off: assert property (supplyLow [*3] |-> !gateOn)
        else $error("gate on during supply lockout");
    a_hot_off: assert property (overTemp [*3] |-> !gateOn)
        else $error("gate on while hot");
    a_sense_nohold: assert property (senseAbsent |-> !supplyHoldLow)
        else $error("supply hold with sense resistor absent");
    a_limit_code: assert property (limitSel != 2'h3)
        else $error("undefined current limit code");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    a_rdata_idle: assert property (!rdPh |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
endmodule
bind osc_switch_ctrl osc_switch_ctrl_monitor i_osc_switch_ctrl_monitor (.*);

//--- osc_fb_model.sv
/*
 * Far-side model: output filter with optocoupler feedback, and the peak
 * current comparator. Assumes gateOn is registered on the same clock.
 */
`timescale 1ns/1ps
module osc_fb_model (
    // clock
    input wire logic clk,
    // bench controls: drain per cycle, trip after so many on cycles
    input wire logic [15:0] load,
    input wire logic [15:0] tripAt,
    // power stage
    input wire logic gateOn,
    output logic fbOutflowHigh,
    output logic peakCurTrip
);
    int v = 0;
    int on = 0;
    always @(posedge clk) begin
        on <= gateOn ? on + 1 : 0;
        v <= (v + (gateOn ? 4 : 0) < int'(load)) ? 0 : v + (gateOn ? 4 : 0) - int'(load);
    end
    // opto pulls the line low only while the output sits above its target
    assign fbOutflowHigh = v > 2000;
    // zero never trips, so only the duty ceiling can end the pulse
    assign peakCurTrip = gateOn && tripAt != 16'h0 && on >= int'(tripAt);
endmodule

//--- tb_osc_switch_ctrl.sv
/*
 * Testbench of the on/off switch controller: bus tasks, pulse counting and
 * pulse width checks against the far-side model.
 * Assumes the checker is bound in its own file.
 */
`timescale 1ns/1ps
module tb_osc_switch_ctrl;
    import osc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supplyLow = 1'b1;
    logic supplyGood = 1'b0;
    logic overTemp = 1'b0;
    logic tempCooled = 1'b1;
    logic lineCurOk = 1'b0;
    logic senseAbsent = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] load = 16'h4;
    logic [15:0] tripAt = 16'h12c;
    wire logic gateOn, regChargeEn, supplyHoldLow, hreadyout, hresp, fbOutflowHigh, peakCurTrip;
    wire logic [1:0] limitSel;
    wire logic [31:0] hrdata;
    int nMismatch = 0;
    int testsRun = 0;
    int n;
    int w;
    logic [31:0] rd;
    always #2 clk = ~clk;
    osc_switch_ctrl i_osc_switch_ctrl (.*, .hready(hreadyout));
    osc_fb_model i_osc_fb_model (.*);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic pulses(input int per);
        logic p;
        n = 0;
        p = gateOn;
        repeat (per * OSC_PER_CYC) begin
            @(posedge clk);
            if (gateOn === 1'b1 && p !== 1'b1) n++;
            p = gateOn;
        end
    endtask
    // skips a pulse already under way so the whole next one is measured
    task automatic width;
        int k;
        w = 0;
        for (k = 0; k < 3 * OSC_PER_CYC && gateOn === 1'b1; k++) @(posedge clk);
        for (k = 0; k < 3 * OSC_PER_CYC && gateOn !== 1'b1; k++) @(posedge clk);
        while (gateOn === 1'b1 && w < 4000) begin
            w++;
            @(posedge clk);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d in %0d checks", nMismatch, testsRun);
        if (nMismatch == 0 && testsRun > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        // the planned run is about 83,000 clocks; this allows some 95,000
        #380000;
        nMismatch++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", CTRL_RST, rd);
        bus(1'b0, 32'hc, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, REG_STAT, 32'h0);
        // low limit, run state, cycle enabled, supply locked, gate off
        chk("stat", {21'h0, LIM_LOW, 3'h1, 6'h12}, rd);
        bus(1'b1, REG_CTRL, 32'h3);
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrlWr", 32'h3, rd);
        bus(1'b1, REG_CTRL, CTRL_RST);
        pulses(2);
        chk("locked", 0, n);
        supplyLow <= 1'b0;
        supplyGood <= 1'b1;
        pulses(2);
        chk("uvHold", 1, supplyHoldLow);
        chk("lineWait", 0, n);
        lineCurOk <= 1'b1;
        pulses(3);
        chk("start", 1, n >= 2);
        chk("limFull", LIM_FULL, limitSel);
        width();
        chk("trip", 1, w >= 300 && w <= 303);
        tripAt <= 16'h5;
        width();
        chk("blank", 1, w >= BLANK_CYC && w <= BLANK_CYC + 3);
        tripAt <= 16'h0;
        width();
        chk("duty", 1, w >= DUTY_CYC - 2 && w <= DUTY_CYC + 2);
        tripAt <= 16'h12c;
        bus(1'b0, REG_ARCNT, 32'h0);
        chk("arRun", 1, rd != 32'h0);
        load <= 16'h0;
        pulses(9);
        pulses(3);
        chk("skip", 0, n);
        chk("limLow", LIM_LOW, limitSel);
        bus(1'b0, REG_ARCNT, 32'h0);
        chk("arClr", 32'h0, rd);
        load <= 16'h4;
        supplyLow <= 1'b1;
        supplyGood <= 1'b0;
        pulses(3);
        chk("uvlo", 0, n);
        supplyLow <= 1'b0;
        pulses(2);
        chk("uvloHold", 0, n);
        supplyGood <= 1'b1;
        pulses(3);
        chk("uvloEnd", 1, n >= 2);
        overTemp <= 1'b1;
        tempCooled <= 1'b0;
        pulses(3);
        chk("hot", 0, n);
        overTemp <= 1'b0;
        pulses(2);
        chk("hotHold", 0, n);
        tempCooled <= 1'b1;
        pulses(3);
        chk("cooled", 1, n >= 2);
        bus(1'b1, REG_CTRL, 32'h0);
        pulses(2);
        chk("ctrlOff", 0, n);
        bus(1'b1, REG_CTRL, CTRL_RST);
        rst_n <= 1'b0;
        senseAbsent <= 1'b1;
        lineCurOk <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        pulses(3);
        chk("noSense", 1, n >= 2);
        chk("noHold", 0, supplyHoldLow);
        complete_run();
    end
endmodule
